// >>> reset_monitor_pkg.sv
// Shared offsets, field positions, reset values and counts for the reset/clock monitor
package reset_monitor_pkg;

  // Register byte addresses
  localparam logic [15:0] RESET_CAUSE_ADDR   = 16'hffac;
  localparam logic [15:0] MON_MODE_ADDR      = 16'hffb0;
  localparam logic [15:0] LV_CONTROL_ADDR    = 16'hffb4;
  localparam logic [15:0] LV_LEVEL_ADDR      = 16'hffb8;
  localparam logic [15:0] MAIN_OSC_CTRL_ADDR = 16'hffbc;
  localparam logic [15:0] MONITOR_STAT_ADDR  = 16'hffc0;

  // Reset cause field positions
  localparam int WATCHDOG_FLAG_BIT = 4;
  localparam int CLOCK_MON_FLAG_BIT = 1;
  localparam int LOW_VOLT_FLAG_BIT = 0;

  // Clock monitor mode and main oscillator control fields
  localparam int MON_ENABLE_BIT = 0;
  localparam int MAIN_OSC_STOP_BIT = 7;
  localparam int MAIN_CLK_SEL_BIT = 0;

  // Monitor status fields
  localparam int STAT_WATCHING_BIT = 0;
  localparam int STAT_STABLE_BIT = 1;

  // Reset values
  localparam logic [7:0] RESET_CAUSE_RESET = 8'h00;
  localparam logic [7:0] MON_MODE_RESET = 8'h00;
  localparam logic [7:0] LV_REG_RESET = 8'h00;
  localparam logic [7:0] MAIN_OSC_RESET = 8'h00;

  // Cycle counts
  localparam int STAB_CYCLES = 65536;
  localparam int STOP_TIMEOUT_CYCLES = 16;

  // Clock monitor state machine
  typedef enum logic [2:0] {
    MON_IDLE  = 3'b001,
    MON_HOLD  = 3'b010,
    MON_WATCH = 3'b100
  } mon_state_t;

endpackage

// >>> clock_stop_detector.sv
// Detects a stalled high-speed clock by sampling it with the reference clock
`timescale 1ns/10ps
`default_nettype none
module clock_stop_detector #(
  parameter int TIMEOUT = reset_monitor_pkg::STOP_TIMEOUT_CYCLES
) (
  // Clock and reset
  input  wire logic ref_clk_in,
  input  wire logic rst_n_in,
  // Control and sample
  input  wire logic enable_in,
  input  wire logic hs_clk_in,
  // Result
  output logic      stopped_out
);

  localparam int CW = $clog2(TIMEOUT + 1);

  logic          hs_prev_q;
  logic [CW-1:0] idle_cnt_q;
  logic          edge_seen;

  assign edge_seen = hs_clk_in ^ hs_prev_q;

  always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      hs_prev_q <= 1'b0;
    end else begin
      hs_prev_q <= hs_clk_in;
    end
  end

  // Cycles since last seen edge
  always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      idle_cnt_q <= '0;
    end else if (!enable_in || edge_seen) begin
      idle_cnt_q <= '0;
    end else if (idle_cnt_q != CW'(TIMEOUT)) begin
      idle_cnt_q <= idle_cnt_q + CW'(1);
    end
  end

  // One-cycle pulse on timeout
  always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      stopped_out <= 1'b0;
    end else begin
      stopped_out <= enable_in && !edge_seen && (idle_cnt_q == CW'(TIMEOUT - 1));
    end
  end

endmodule
`default_nettype wire

// >>> reset_source_and_clock_monitor.sv
// Reset cause recording and high-speed clock supervision with Wishbone registers
// Functional notes
// [RQ1] Keep a byte-wide reset cause register showing the latest internal reset source.
// [RQ2] External reset, power-on clear and a software read of the cause register clear the cause register.
// [RQ3] Watchdog flag bit 4, clock monitor bit 1, low voltage bit 0; others zero.
// [RQ4] Software reads the cause register only as a whole byte.
// [RQ5] Watchdog reset sets its flag, other flags held.
// [RQ6] Clock monitor reset sets bit 1, other flags held.
// [RQ7] Low-voltage reset sets its flag, other flags held.
// [RQ8] Low-voltage registers cleared by all resets except the low-voltage reset.
// [RQ9] Sample high-speed clock with reference clock; reset when it stops.
// [RQ10] No monitoring after reset release until stabilization time ends.
// [RQ11] No monitoring in deep stop and during the following stabilization.
// [RQ12] No monitoring while software stops the main clock, and during restabilization.
// [RQ13] No monitoring while the internal sampling oscillator is stopped.
// [RQ14] Monitoring begins only after software writes enable bit 0 to one.
// [RQ15] Enable bit ignores software zero; only resets clear it.
// [RQ16] A clock monitor reset clears the enable bit and sets its cause flag.
// [RQ17] Enabled while suspended, monitoring starts by itself after stabilization.
// [RQ18] A new cause event wins over a simultaneous read clear.
`timescale 1ns/10ps
`default_nettype none
module reset_source_and_clock_monitor #(
  parameter int STAB_CYCLES = reset_monitor_pkg::STAB_CYCLES,
  parameter int STOP_TIMEOUT = reset_monitor_pkg::STOP_TIMEOUT_CYCLES
) (
  // Clock and reset
  input  wire logic        ref_clk_in,
  input  wire logic        rst_n_in,
  // Wishbone slave
  input  wire logic        wb_cyc_in,
  input  wire logic        wb_stb_in,
  input  wire logic        wb_we_in,
  input  wire logic [15:0] wb_adr_in,
  input  wire logic [3:0]  wb_sel_in,
  input  wire logic [31:0] wb_dat_in,
  output logic      [31:0] wb_dat_out,
  output logic             wb_ack_out,
  // Reset sources
  input  wire logic        power_on_clear_in,
  input  wire logic        watchdog_reset_in,
  input  wire logic        low_voltage_reset_in,
  // Clock status
  input  wire logic        hs_clk_in,
  input  wire logic        int_osc_running_in,
  input  wire logic        deep_stop_in,
  // Outputs
  output logic             clock_monitor_reset_out,
  output logic      [7:0]  low_voltage_control_out,
  output logic      [7:0]  low_voltage_level_out,
  output logic             main_osc_stop_out,
  output logic             main_clock_select_out
);

  localparam int SW = $clog2(STAB_CYCLES + 1);

  // Register state
  logic [7:0] reset_cause_q;
  logic [7:0] reset_cause_d;
  logic       mon_enable_q;
  logic [7:0] lv_control_q;
  logic [7:0] lv_level_q;
  logic [7:0] main_osc_q;
  logic       ack_q;
  logic [31:0] rdata_q;

  // Monitor state
  reset_monitor_pkg::mon_state_t state_q;
  reset_monitor_pkg::mon_state_t state_d;
  logic [SW-1:0] stab_cnt_q;
  logic          stab_done_q;
  logic          mon_reset_q;
  logic          hs_stopped;

  // Bus decode, suspend, internal reset and watching terms
  logic bus_req;
  logic wr_en;
  logic rd_en;
  logic sw_stop;
  logic suspend;
  logic any_int_reset;
  logic watching;

  function automatic logic hit(input logic [15:0] adr, input logic [15:0] reg_addr);
    hit = (adr[15:2] == reg_addr[15:2]);
  endfunction

  assign bus_req = wb_cyc_in && wb_stb_in && !ack_q;
  assign wr_en = bus_req && wb_we_in && wb_sel_in[0];
  assign rd_en = bus_req && !wb_we_in;
  assign wb_ack_out = ack_q;
  assign wb_dat_out = rdata_q;

  assign sw_stop = main_osc_q[reset_monitor_pkg::MAIN_OSC_STOP_BIT] ||
                   main_osc_q[reset_monitor_pkg::MAIN_CLK_SEL_BIT];
  assign suspend = deep_stop_in || sw_stop || !int_osc_running_in; // [RQ11] [RQ12] [RQ13]
  assign any_int_reset = watchdog_reset_in || low_voltage_reset_in || mon_reset_q ||
                         power_on_clear_in;
  assign watching = (state_q == reset_monitor_pkg::MON_WATCH);

  assign clock_monitor_reset_out = mon_reset_q;
  assign low_voltage_control_out = lv_control_q;
  assign low_voltage_level_out = lv_level_q;
  assign main_osc_stop_out = main_osc_q[reset_monitor_pkg::MAIN_OSC_STOP_BIT];
  assign main_clock_select_out = main_osc_q[reset_monitor_pkg::MAIN_CLK_SEL_BIT];

  // Bus acknowledge, one cycle after request
  always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      ack_q <= 1'b0;
    end else begin
      ack_q <= bus_req;
    end
  end

  // Read data capture
  always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      rdata_q <= 32'h0000_0000;
    end else if (rd_en) begin
      rdata_q <= 32'h0000_0000;
      if (hit(wb_adr_in, reset_monitor_pkg::RESET_CAUSE_ADDR)) begin
        rdata_q[7:0] <= reset_cause_q; // [RQ1]
      end else if (hit(wb_adr_in, reset_monitor_pkg::MON_MODE_ADDR)) begin
        rdata_q[reset_monitor_pkg::MON_ENABLE_BIT] <= mon_enable_q;
      end else if (hit(wb_adr_in, reset_monitor_pkg::LV_CONTROL_ADDR)) begin
        rdata_q[7:0] <= lv_control_q;
      end else if (hit(wb_adr_in, reset_monitor_pkg::LV_LEVEL_ADDR)) begin
        rdata_q[7:0] <= lv_level_q;
      end else if (hit(wb_adr_in, reset_monitor_pkg::MAIN_OSC_CTRL_ADDR)) begin
        rdata_q[7:0] <= main_osc_q;
      end else if (hit(wb_adr_in, reset_monitor_pkg::MONITOR_STAT_ADDR)) begin
        rdata_q[reset_monitor_pkg::STAT_WATCHING_BIT] <= watching;
        rdata_q[reset_monitor_pkg::STAT_STABLE_BIT] <= stab_done_q;
      end
    end
  end

  // Reset cause next value
  always_comb begin
    reset_cause_d = reset_cause_q;
    if (power_on_clear_in) begin
      reset_cause_d = reset_monitor_pkg::RESET_CAUSE_RESET; // [RQ2]
    end else begin
      if (rd_en && hit(wb_adr_in, reset_monitor_pkg::RESET_CAUSE_ADDR)) begin
        reset_cause_d = reset_monitor_pkg::RESET_CAUSE_RESET; // [RQ2] [RQ4]
      end
      if (watchdog_reset_in) begin
        reset_cause_d[reset_monitor_pkg::WATCHDOG_FLAG_BIT] = 1'b1; // [RQ5] [RQ18]
      end
      if (mon_reset_q) begin
        reset_cause_d[reset_monitor_pkg::CLOCK_MON_FLAG_BIT] = 1'b1; // [RQ6] [RQ16] [RQ18]
      end
      if (low_voltage_reset_in) begin
        reset_cause_d[reset_monitor_pkg::LOW_VOLT_FLAG_BIT] = 1'b1; // [RQ7] [RQ18]
      end
    end
    reset_cause_d[7:5] = 3'h0; // [RQ3]
    reset_cause_d[3:2] = 2'h0; // [RQ3]
  end

  always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      reset_cause_q <= reset_monitor_pkg::RESET_CAUSE_RESET; // [RQ2]
    end else begin
      reset_cause_q <= reset_cause_d;
    end
  end

  // Clock monitor enable
  always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      mon_enable_q <= reset_monitor_pkg::MON_MODE_RESET[0];
    end else if (any_int_reset) begin
      mon_enable_q <= 1'b0; // [RQ15] [RQ16]
    end else if (wr_en && hit(wb_adr_in, reset_monitor_pkg::MON_MODE_ADDR) &&
                 wb_dat_in[reset_monitor_pkg::MON_ENABLE_BIT]) begin
      mon_enable_q <= 1'b1; // [RQ14] [RQ15]
    end
  end

  // Low-voltage registers
  always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      lv_control_q <= reset_monitor_pkg::LV_REG_RESET;
      lv_level_q <= reset_monitor_pkg::LV_REG_RESET;
    end else if (power_on_clear_in || watchdog_reset_in || mon_reset_q) begin
      lv_control_q <= reset_monitor_pkg::LV_REG_RESET; // [RQ8]
      lv_level_q <= reset_monitor_pkg::LV_REG_RESET; // [RQ8]
    end else if (!low_voltage_reset_in && wr_en) begin
      if (hit(wb_adr_in, reset_monitor_pkg::LV_CONTROL_ADDR)) begin
        lv_control_q <= wb_dat_in[7:0];
      end
      if (hit(wb_adr_in, reset_monitor_pkg::LV_LEVEL_ADDR)) begin
        lv_level_q <= wb_dat_in[7:0];
      end
    end
  end

  // Main oscillator control
  always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      main_osc_q <= reset_monitor_pkg::MAIN_OSC_RESET;
    end else if (any_int_reset) begin
      main_osc_q <= reset_monitor_pkg::MAIN_OSC_RESET;
    end else if (wr_en && hit(wb_adr_in, reset_monitor_pkg::MAIN_OSC_CTRL_ADDR)) begin
      main_osc_q <= wb_dat_in[7:0];
    end
  end

  // Oscillation stabilization wait
  always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      stab_cnt_q <= '0; // [RQ10]
      stab_done_q <= 1'b0;
    end else if (any_int_reset || deep_stop_in || sw_stop) begin
      stab_cnt_q <= '0; // [RQ10] [RQ11] [RQ12]
      stab_done_q <= 1'b0;
    end else if (!stab_done_q) begin
      if (stab_cnt_q == SW'(STAB_CYCLES - 1)) begin
        stab_done_q <= 1'b1;
      end
      stab_cnt_q <= stab_cnt_q + SW'(1);
    end
  end

  // Monitor state machine
  always_comb begin
    state_d = state_q;
    case (state_q)
      reset_monitor_pkg::MON_IDLE: begin
        if (mon_enable_q) begin
          state_d = reset_monitor_pkg::MON_HOLD; // [RQ14]
        end
      end
      reset_monitor_pkg::MON_HOLD: begin
        if (!mon_enable_q) begin
          state_d = reset_monitor_pkg::MON_IDLE;
        end else if (stab_done_q && !suspend) begin
          state_d = reset_monitor_pkg::MON_WATCH; // [RQ10] [RQ17]
        end
      end
      reset_monitor_pkg::MON_WATCH: begin
        if (!mon_enable_q || hs_stopped) begin
          state_d = reset_monitor_pkg::MON_IDLE;
        end else if (suspend || !stab_done_q) begin
          state_d = reset_monitor_pkg::MON_HOLD; // [RQ11] [RQ12] [RQ13]
        end
      end
      default: begin
        state_d = reset_monitor_pkg::MON_IDLE;
      end
    endcase
  end

  always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      state_q <= reset_monitor_pkg::MON_IDLE;
    end else begin
      state_q <= state_d;
    end
  end

  // Internal reset request from the monitor
  always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      mon_reset_q <= 1'b0;
    end else begin
      mon_reset_q <= watching && hs_stopped && mon_enable_q && !suspend; // [RQ9]
    end
  end

  clock_stop_detector #(
    .TIMEOUT (STOP_TIMEOUT)
  ) i_clock_stop_detector (
    .ref_clk_in  (ref_clk_in),
    .rst_n_in    (rst_n_in),
    .enable_in   (watching && !suspend), // [RQ9] [RQ13]
    .hs_clk_in   (hs_clk_in),
    .stopped_out (hs_stopped)
  );

endmodule
`default_nettype wire

// >>> reset_monitor_checker_asserts.sv
// Port checker for reset cause recording and clock supervision
`timescale 1ns/10ps
`default_nettype none
module reset_monitor_checker #(
  parameter int STAB_CYCLES = 32
) (
  // Clock, reset and bus
  input wire logic        ref_clk_in,
  input wire logic        rst_n_in,
  input wire logic        wb_cyc_in,
  input wire logic        wb_stb_in,
  input wire logic        wb_we_in,
  input wire logic [15:0] wb_adr_in,
  input wire logic [31:0] wb_dat_out,
  input wire logic        wb_ack_out,
  // Sources and monitor
  input wire logic        power_on_clear_in,
  input wire logic        watchdog_reset_in,
  input wire logic        low_voltage_reset_in,
  input wire logic        int_osc_running_in,
  input wire logic        deep_stop_in,
  input wire logic        clock_monitor_reset_out,
  input wire logic [7:0]  low_voltage_control_out
);
  default clocking cb @(posedge ref_clk_in);
  endclocking
  default disable iff (!rst_n_in);
  wire taken = wb_cyc_in && wb_stb_in && !wb_ack_out;
  wire cause_rd = taken && !wb_we_in && wb_adr_in == reset_monitor_pkg::RESET_CAUSE_ADDR;
  int unsigned since_q;
  // Cycles since the last reset, saturating
  always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
    if (!rst_n_in)
      since_q <= 0;
    else if (power_on_clear_in || watchdog_reset_in || low_voltage_reset_in || clock_monitor_reset_out)
      since_q <= 0;
    else if (since_q < STAB_CYCLES)
      since_q <= since_q + 1;
  end
  a_ack_answer: assert property (taken |=> wb_ack_out ##1 !wb_ack_out)
    else $error("ack timing wrong");
  a_cause_zero_bits: assert property (cause_rd |=> wb_dat_out[31:5] == 27'h0 && wb_dat_out[3:2] == 2'h0)
    else $error("cause unused bits set");
  a_lv_cleared: assert property (watchdog_reset_in || power_on_clear_in |-> ##[1:2] low_voltage_control_out == 8'h00)
    else $error("lv control not cleared");
  a_lv_held: assert property (low_voltage_reset_in && !watchdog_reset_in && !power_on_clear_in && !clock_monitor_reset_out |=> $stable(low_voltage_control_out))
    else $error("lv control lost");
  a_mon_single: assert property (clock_monitor_reset_out |=> !clock_monitor_reset_out && low_voltage_control_out == 8'h00)
    else $error("monitor reset wrong");
  a_stab_quiet: assert property (since_q < STAB_CYCLES |-> !clock_monitor_reset_out)
    else $error("monitor reset in stabilization");
  a_deep_quiet: assert property (deep_stop_in [*4] |-> !clock_monitor_reset_out)
    else $error("monitor reset in deep stop");
  a_osc_quiet: assert property (!int_osc_running_in [*4] |-> !clock_monitor_reset_out)
    else $error("monitor reset without oscillator");
  c_mon_reset: cover property (clock_monitor_reset_out);
  c_dog_reset: cover property (watchdog_reset_in);
  c_cause_rd: cover property (cause_rd);
endmodule
bind reset_source_and_clock_monitor reset_monitor_checker #(.STAB_CYCLES(STAB_CYCLES)) i_chk (
  .ref_clk_in(ref_clk_in), .rst_n_in(rst_n_in), .wb_cyc_in(wb_cyc_in), .wb_stb_in(wb_stb_in),
  .wb_we_in(wb_we_in), .wb_adr_in(wb_adr_in), .wb_dat_out(wb_dat_out), .wb_ack_out(wb_ack_out),
  .power_on_clear_in(power_on_clear_in), .watchdog_reset_in(watchdog_reset_in),
  .low_voltage_reset_in(low_voltage_reset_in), .int_osc_running_in(int_osc_running_in),
  .deep_stop_in(deep_stop_in), .clock_monitor_reset_out(clock_monitor_reset_out),
  .low_voltage_control_out(low_voltage_control_out)
);
`default_nettype wire

// >>> tb_reset_source_and_clock_monitor.sv
// Testbench for reset cause register and clock monitor
`timescale 1ns/10ps
`default_nettype none
module tb_reset_source_and_clock_monitor;
  localparam int STAB = 32;
  logic        clk = 1'b0;
  logic        rst_n;
  logic        req;
  logic        we;
  logic [15:0] adr;
  logic [31:0] dat;
  logic [31:0] dout;
  logic        ack;
  logic [2:0]  src;
  logic        hs;
  logic        hs_run;
  logic        osc_on;
  logic        deep;
  logic        mon_rst;
  logic [7:0]  lvc;
  logic [7:0]  lvl;
  logic [7:0]  q;
  int          n_fail = 0;
  int          checks_done = 0;
  int          n_mon_rst = 0;
  always #20 clk = ~clk;
  always @(posedge clk) begin
    if (hs_run) hs <= ~hs;
    if (mon_rst === 1'b1) n_mon_rst <= n_mon_rst + 1;
  end
  reset_source_and_clock_monitor #(.STAB_CYCLES(STAB), .STOP_TIMEOUT(4))
    i_reset_source_and_clock_monitor (
    .ref_clk_in(clk), .rst_n_in(rst_n), .wb_cyc_in(req), .wb_stb_in(req), .wb_we_in(we),
    .wb_adr_in(adr), .wb_sel_in(4'hf), .wb_dat_in(dat), .wb_dat_out(dout), .wb_ack_out(ack),
    .power_on_clear_in(src[1]), .watchdog_reset_in(src[0]), .low_voltage_reset_in(src[2]),
    .hs_clk_in(hs), .int_osc_running_in(osc_on), .deep_stop_in(deep),
    .clock_monitor_reset_out(mon_rst), .low_voltage_control_out(lvc),
    .low_voltage_level_out(lvl), .main_osc_stop_out(), .main_clock_select_out());
  task automatic chk(input string s, input logic [7:0] e, input logic [7:0] g);
    checks_done++;
    if (g !== e) begin
      n_fail++;
      $display("mismatch %s expected %h seen %h", s, e, g);
    end
  endtask
  task automatic wb(input logic w, input logic [15:0] a, input logic [7:0] d);
    int n;
    @(posedge clk);
    we <= w;
    adr <= a;
    dat <= {24'h0, d};
    req <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (ack !== 1'b1 && n < 20);
    q = dout[7:0];
    req <= 1'b0;
    chk("ack", 8'h01, {7'h0, ack});
  endtask
  task automatic rd(input logic [15:0] a, input logic [7:0] e, input string s);
    wb(1'b0, a, 8'h00);
    chk(s, e, q);
  endtask
  task automatic rc(input logic [7:0] e, input string s);
    rd(reset_monitor_pkg::RESET_CAUSE_ADDR, e, s);
  endtask
  task automatic pulse(input logic [2:0] v);
    @(posedge clk);
    src <= v;
    @(posedge clk);
    src <= 3'h0;
    repeat (2) @(posedge clk);
  endtask
  task automatic lv_set();
    wb(1'b1, reset_monitor_pkg::LV_CONTROL_ADDR, 8'h5a);
    wb(1'b1, reset_monitor_pkg::LV_LEVEL_ADDR, 8'ha5);
  endtask
  task automatic suspend(input int k, input logic on);
    @(posedge clk);
    if (k == 0) deep <= on;
    if (k == 1) osc_on <= !on;
    if (k == 2) wb(1'b1, reset_monitor_pkg::MAIN_OSC_CTRL_ADDR, {on, 7'h00});
    @(posedge clk);
  endtask
  task automatic close_out();
    $display("checks %0d mismatches %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  initial begin
    repeat (3000) @(posedge clk);
    n_fail++;
    close_out();
  end
  initial begin
    int n;
    rst_n = 1'b0;
    req = 1'b0;
    we = 1'b0;
    adr = 16'h0000;
    dat = 32'h0;
    src = 3'h0;
    hs = 1'b0;
    hs_run = 1'b0;
    osc_on = 1'b1;
    deep = 1'b0;
    repeat (16) @(posedge clk);
    rst_n <= 1'b1;
    rc(8'h00, "cause_after_reset");
    wb(1'b1, reset_monitor_pkg::RESET_CAUSE_ADDR, 8'hff);
    rc(8'h00, "cause_read_only");
    rd(16'h0000, 8'h00, "unmapped");
    lv_set();
    pulse(3'b001);
    chk("lv_ctl_dog", 8'h00, lvc);
    rc(8'h10, "cause_dog");
    rc(8'h00, "cause_read_clear");
    lv_set();
    pulse(3'b100);
    chk("lv_ctl_low", 8'h5a, lvc);
    chk("lv_lvl_low", 8'ha5, lvl);
    pulse(3'b001);
    rc(8'h11, "cause_low_dog");
    fork
      wb(1'b0, reset_monitor_pkg::RESET_CAUSE_ADDR, 8'h00);
      pulse(3'b100);
    join
    rc(8'h01, "cause_set_wins");
    pulse(3'b001);
    pulse(3'b010);
    rc(8'h00, "cause_power_on");
    repeat (60) @(posedge clk);
    chk("mon_disabled", 8'h00, n_mon_rst[7:0]);
    pulse(3'b001);
    wb(1'b1, reset_monitor_pkg::MON_MODE_ADDR, 8'h01);
    n = 0;
    while (mon_rst !== 1'b1 && n < 100) begin
      @(posedge clk);
      n++;
    end
    chk("mon_delay", 8'h01, 8'(n >= STAB - 6 && n < STAB + 20));
    rc(8'h12, "cause_mon");
    rd(reset_monitor_pkg::MON_MODE_ADDR, 8'h00, "enable_cleared");
    hs_run <= 1'b1;
    wb(1'b1, reset_monitor_pkg::MON_MODE_ADDR, 8'h01);
    wb(1'b1, reset_monitor_pkg::MON_MODE_ADDR, 8'h00);
    rd(reset_monitor_pkg::MON_MODE_ADDR, 8'h01, "enable_sticky");
    for (int k = 0; k < 3; k++) begin
      suspend(k, 1'b1);
      hs_run <= 1'b0;
      repeat (STAB + 8) @(posedge clk);
      chk("mon_suspended", 8'h01, n_mon_rst[7:0]);
      hs_run <= 1'b1;
      suspend(k, 1'b0);
      repeat (STAB + 8) @(posedge clk);
      rd(reset_monitor_pkg::MONITOR_STAT_ADDR, 8'h03, "resumed");
    end
    hs_run <= 1'b0;
    repeat (12) @(posedge clk);
    chk("mon_live", 8'h02, n_mon_rst[7:0]);
    close_out();
  end
endmodule
`default_nettype wire
